// ===== common/hsr_pkg.sv
`default_nettype none
package hsr_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 5; // 200 MHz reference clock
	localparam int HOST_RST_FILTER_NS = 40; // Least valid host reset low
	// Host reset low must last more than this many cycles
	localparam int HOST_RST_FILTER_CYC =
		(HOST_RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_STRETCH_DEF_CYC = 1000; // Default stretch length

	// ****************************************
	// Synchroniser bit positions
	// ****************************************
	localparam int SYNC_W = 11;
	localparam int IDX_HOST_RST_N = 0;
	localparam int IDX_PWR_REQ = 1;
	localparam int IDX_CHOICE = 2;
	localparam int IDX_INS_A_N = 3;
	localparam int IDX_INS_B_N = 4;
	localparam int IDX_BRK_LO = 5;
	localparam int IDX_BRK_HI = 6;
	localparam int IDX_HOST_LO_MON = 7;
	localparam int IDX_MAIN_MON = 8;
	localparam int IDX_CARD_LO_MON = 9;
	localparam int IDX_CARD_HI_MON = 10;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] OFS_CTRL = 4'h0; // Control, read/write
	localparam logic [3:0] OFS_STATUS = 4'h4; // Live status, read only
	localparam logic [3:0] OFS_STRAP = 4'h8; // Captured straps, read only
	localparam int CTRL_SOFT_RST_BIT = 0; // Forces local resets
	localparam logic CTRL_SOFT_RST_RST = 1'b0;
	localparam int ST_GATE_BIT = 0;
	localparam int ST_FAULT_BIT = 1;
	localparam int ST_PGOOD_BIT = 2;
	localparam int ST_SVALID_BIT = 3;
	localparam int ST_RESET_BIT = 4;
	localparam int ST_INPUTS_LSB = 5; // Five synced host inputs, then low-rail breaker
	localparam int ST_HOST_BAD_BIT = 11;
	localparam int ST_CARD_BAD_BIT = 12;
	localparam int ST_PINS_LSB = 16; // Six open-drain pin levels
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== core/hsr_sequencer.sv
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`default_nettype none
// Overview of operation
// - Host reset low over 40ns starts sequence
// - Resets held stretch interval, longer if low
// - Power request low: gates off, resets on
// - Trip latched until power request low-high
// - Either breaker comparator means over-current
// - Over-current drops both gates, reports fault
// - Fault flag low while over-current latched
// - Fault clears with gate re-enable edge
// - Card monitor low: no good, no valid, reset
// - Host low rail bad: no valid, gates, reset
// - Static choice picks monitored host supply
// - Main bad with choice low: all down
// - Both insertion inputs low before power on
// - Driver status flag follows gate drivers
// - Power good only with card monitors ok
// - Local reset on card low or host reset
// - High reset is inverse of low reset
// - Signal valid needs card ok and timer done
// - Two straps form memory address field
// - Power-up: resets on, gates off, no good
module hsr_sequencer import hsr_pkg::*; #(
	parameter int STRETCH_CYCLES = RST_STRETCH_DEF_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Host backplane inputs
	input wire logic hostResetN,
	input wire logic hostPowerRequest,
	input wire logic hostSupplyChoice,
	input wire logic insertionDetectAN,
	input wire logic insertionDetectBN,
	// Comparator inputs, high means tripped or above level
	input wire logic breakerSenseLowRail,
	input wire logic breakerSenseHighRail,
	input wire logic hostLowRailMonitor,
	input wire logic mainSupplyMonitor,
	input wire logic cardLowRailMonitor,
	input wire logic cardHighRailMonitor,
	// Memory address straps
	input wire logic memAddrStrap1,
	input wire logic memAddrStrap2,
	input wire logic memAddrStrapUnused,
	output logic [1:0] memAddrField,
	// Gate controls
	output logic gateCtrlLowRail,
	output logic gateCtrlHighRail,
	// Open-drain driver status
	input wire logic gateDriverStatusNIn,
	output logic gateDriverStatusNOut,
	output logic gateDriverStatusNOe,
	// Open-drain power good
	input wire logic cardPowerGoodNIn,
	output logic cardPowerGoodNOut,
	output logic cardPowerGoodNOe,
	// Open-drain signal valid
	input wire logic cardSignalValidNIn,
	output logic cardSignalValidNOut,
	output logic cardSignalValidNOe,
	// Open-drain fault flag
	input wire logic faultNIn,
	output logic faultNOut,
	output logic faultNOe,
	// Open-drain local resets, low and high active
	input wire logic localResetNIn,
	output logic localResetNOut,
	output logic localResetNOe,
	input wire logic localResetIn,
	output logic localResetOut,
	output logic localResetOe,
	// AXI4-Lite write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	localparam int STRETCH_W = $clog2(STRETCH_CYCLES + 1);
	localparam int LOW_CNT_W = $clog2(HOST_RST_FILTER_CYC + 2);
	localparam logic [LOW_CNT_W-1:0] LOW_CNT_END =
		LOW_CNT_W'(HOST_RST_FILTER_CYC);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [SYNC_W-1:0] syncRaw; // Gathered raw inputs
	logic [SYNC_W-1:0] sync1_q; // First stage, read only by second
	logic [SYNC_W-1:0] sync2_q; // Stable copy used by the logic

	assign syncRaw = {cardHighRailMonitor, cardLowRailMonitor,
		mainSupplyMonitor, hostLowRailMonitor, breakerSenseHighRail,
		breakerSenseLowRail, insertionDetectBN, insertionDetectAN,
		hostSupplyChoice, hostPowerRequest, hostResetN};

	// Two flops per input, both reset to zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= syncRaw;
			sync2_q <= sync1_q;
		end
	end

	// ****************************************
	// Decoded conditions
	// ****************************************
	logic hostRstLow; // Synced host reset is low
	logic pwrReq; // Host asks for power
	logic cardOk; // Both card rails above trip
	logic mainBad; // Main supply low in 5V mode
	logic hostBad; // Monitored host supply low
	logic trip; // Any breaker tripped
	logic insDone; // Board fully inserted

	assign hostRstLow = ~sync2_q[IDX_HOST_RST_N];
	assign pwrReq = sync2_q[IDX_PWR_REQ];
	assign cardOk = sync2_q[IDX_CARD_LO_MON] & sync2_q[IDX_CARD_HI_MON];
	// Choice low watches the main supply as well
	assign mainBad = ~sync2_q[IDX_CHOICE] & ~sync2_q[IDX_MAIN_MON];
	assign hostBad = ~sync2_q[IDX_HOST_LO_MON] | mainBad;
	assign trip = sync2_q[IDX_BRK_LO] | sync2_q[IDX_BRK_HI];
	assign insDone = ~sync2_q[IDX_INS_A_N] & ~sync2_q[IDX_INS_B_N];

	// ****************************************
	// Host reset filter
	// ****************************************
	logic [LOW_CNT_W-1:0] lowCnt_q; // Consecutive low samples
	logic armed_q; // High seen since last start
	logic rstStart; // Filtered start pulse

	// Count low samples, saturating past the end
	always_ff @(posedge ref_clk) begin
		if (rst || !hostRstLow) begin
			lowCnt_q <= '0;
		end else if (lowCnt_q <= LOW_CNT_END) begin
			lowCnt_q <= lowCnt_q + LOW_CNT_W'(1);
		end
	end

	// Arm on high so only a falling edge starts
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (!hostRstLow) begin
			armed_q <= 1'b1;
		end else if (rstStart) begin
			armed_q <= 1'b0;
		end
	end

	// Start on the sample that passes the filter time
	assign rstStart = hostRstLow & armed_q & (lowCnt_q == LOW_CNT_END);

	// ****************************************
	// Reset stretch and hold
	// ****************************************
	logic ctrlSoftRst_q; // Software forced reset
	logic otherCause; // Level causes of local reset
	logic [STRETCH_W-1:0] stretchCnt_q; // Remaining stretch
	logic seqHold_q; // Sequence running, host still low
	logic resetActive_d; // Next local reset level

	assign otherCause = ~pwrReq | ~cardOk | hostBad | ctrlSoftRst_q;

	// Reload on start and level causes, count down once those are gone
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stretchCnt_q <= STRETCH_W'(STRETCH_CYCLES);
		end else if (rstStart || otherCause) begin
			stretchCnt_q <= STRETCH_W'(STRETCH_CYCLES);
		end else if (stretchCnt_q != '0) begin
			stretchCnt_q <= stretchCnt_q - STRETCH_W'(1);
		end
	end

	// Keep the sequence alive while the host holds it low
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seqHold_q <= 1'b0;
		end else if (rstStart) begin
			seqHold_q <= 1'b1;
		end else if (!hostRstLow) begin
			seqHold_q <= 1'b0;
		end
	end

	assign resetActive_d = otherCause | rstStart | (stretchCnt_q != '0) |
		(seqHold_q & hostRstLow);

	// ****************************************
	// Over-current latch
	// ****************************************
	logic ocLatch_q; // Latched over-current
	logic ocLatch_d;
	logic pwrLowSeen_q; // Request went low since the trip
	logic gateAllowed; // All gate conditions met

	// Trip sets; a low-high request cycle clears; set wins
	always_comb begin
		ocLatch_d = ocLatch_q;
		if (trip) begin
			ocLatch_d = 1'b1;
		end else if (ocLatch_q && pwrLowSeen_q && pwrReq) begin
			ocLatch_d = 1'b0;
		end
	end

	// Latch state and the seen-low marker
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ocLatch_q <= 1'b0;
			pwrLowSeen_q <= 1'b0;
		end else begin
			ocLatch_q <= ocLatch_d;
			pwrLowSeen_q <= ocLatch_d & (pwrLowSeen_q | ~pwrReq);
		end
	end

	assign gateAllowed = insDone & pwrReq & ~ocLatch_d & ~hostBad;

	// ****************************************
	// Output flops
	// ****************************************
	logic gateOn_q; // Both gate drivers on
	logic resetOn_q; // Local resets asserted
	logic pgood_q; // Card power good
	logic svalid_q; // Card signals valid

	// Fault and gate share one edge so they change together
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gateOn_q <= 1'b0;
			resetOn_q <= 1'b1;
			pgood_q <= 1'b0;
			svalid_q <= 1'b0;
		end else begin
			gateOn_q <= gateAllowed;
			resetOn_q <= resetActive_d;
			pgood_q <= cardOk & ~mainBad;
			svalid_q <= cardOk & ~hostBad & ~resetActive_d;
		end
	end

	// Gate and flag pins
	assign gateCtrlLowRail = gateOn_q;
	assign gateCtrlHighRail = gateOn_q;
	assign gateDriverStatusNOut = 1'b0;
	assign gateDriverStatusNOe = gateOn_q;
	assign cardPowerGoodNOut = 1'b0;
	assign cardPowerGoodNOe = pgood_q;
	assign cardSignalValidNOut = 1'b0;
	assign cardSignalValidNOe = svalid_q;
	assign faultNOut = 1'b0;
	assign faultNOe = ocLatch_q;
	// Both resets from one flop so they never skew
	assign localResetNOut = 1'b0;
	assign localResetNOe = resetOn_q;
	assign localResetOut = 1'b1;
	assign localResetOe = resetOn_q;

	// ****************************************
	// Strap capture
	// ****************************************
	logic strapDone_q; // Straps taken after release
	logic [1:0] strapField_q;
	logic strapSpare_q; // Level of the ignored strap

	// Caught once on the first edge after reset release
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strapDone_q <= 1'b0;
			strapField_q <= 2'h0;
			strapSpare_q <= 1'b0;
		end else if (!strapDone_q) begin
			strapDone_q <= 1'b1;
			strapField_q <= {memAddrStrap2, memAddrStrap1};
			strapSpare_q <= memAddrStrapUnused;
		end
	end

	assign memAddrField = strapField_q;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic awHeld_q; // Write address taken
	logic wHeld_q; // Write data taken
	logic [3:0] awOfs_q;
	logic awMap_q; // Address inside the window
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic doWrite;
	logic [31:0] statusWord;

	// Word-aligned offset check shared by both paths
	function automatic logic inMap(input logic [31:0] a);
		inMap = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0) &&
			(a[3:0] != 4'hC);
	endfunction

	assign awready = ~awHeld_q & ~bvalid_q;
	assign wready = ~wHeld_q & ~bvalid_q;
	assign doWrite = awHeld_q & wHeld_q & ~bvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = ~rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Take address and data in either order
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awOfs_q <= 4'h0;
			awMap_q <= 1'b0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awOfs_q <= awaddr[3:0];
				awMap_q <= inMap(awaddr);
			end else if (doWrite) begin
				awHeld_q <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end else if (doWrite) begin
				wHeld_q <= 1'b0;
			end
		end
	end

	// Commit the write and raise the response
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrlSoftRst_q <= CTRL_SOFT_RST_RST;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q <= awMap_q ? RESP_OKAY : RESP_SLVERR;
			// Only the control word is writable
			if (awOfs_q == OFS_CTRL && wStrb_q[0]) begin
				ctrlSoftRst_q <= wData_q[CTRL_SOFT_RST_BIT];
			end
		end else if (bvalid_q && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Live status word
	always_comb begin
		statusWord = 32'h00000000;
		statusWord[ST_GATE_BIT] = gateOn_q;
		statusWord[ST_FAULT_BIT] = ocLatch_q;
		statusWord[ST_PGOOD_BIT] = pgood_q;
		statusWord[ST_SVALID_BIT] = svalid_q;
		statusWord[ST_RESET_BIT] = resetOn_q;
		statusWord[ST_INPUTS_LSB +: 6] = sync2_q[5:0];
		statusWord[ST_HOST_BAD_BIT] = hostBad;
		statusWord[ST_CARD_BAD_BIT] = ~cardOk;
		statusWord[ST_PINS_LSB +: 6] = {localResetIn, localResetNIn,
			faultNIn, cardSignalValidNIn, cardPowerGoodNIn,
			gateDriverStatusNIn};
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= inMap(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr[3:0])
				OFS_CTRL: begin
					rdata_q <= {31'h00000000, ctrlSoftRst_q};
				end
				OFS_STATUS: begin
					rdata_q <= statusWord;
				end
				OFS_STRAP: begin
					rdata_q <= {29'h00000000, strapSpare_q, strapField_q};
				end
				default: begin
					rdata_q <= 32'h00000000;
				end
			endcase
			if (!inMap(araddr)) begin
				rdata_q <= 32'h00000000;
			end
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_req_low_off: assert property (!pwrReq |=>
		!gateCtrlLowRail && !gateCtrlHighRail && localResetNOe)
		else $error("gates on or reset off with request low");
	a_trip_drops: assert property (trip |=>
		!gateCtrlLowRail && !gateCtrlHighRail && faultNOe)
		else $error("trip did not drop gates and raise fault");
	a_fault_holds: assert property (ocLatch_q && !pwrLowSeen_q
		|=> ocLatch_q)
		else $error("fault cleared without request cycle");
	a_fault_clear: assert property ($fell(faultNOe) |->
		$past(pwrLowSeen_q) && $past(pwrReq))
		else $error("fault cleared out of turn");
	a_short_filter: assert property (rstStart |->
		hostRstLow && $past(hostRstLow, 8) && !$past(hostRstLow, 9))
		else $error("reset sequence started on short pulse");
	a_stretch_min: assert property (rstStart |=>
		localResetNOe [*8])
		else $error("reset not stretched after start");
	a_rst_pair: assert property (localResetNOe == localResetOe)
		else $error("reset outputs disagree");
	a_valid_timer: assert property (cardSignalValidNOe |->
		stretchCnt_q == '0 && !resetOn_q)
		else $error("signal valid before timer done");
	a_card_bad: assert property (!cardOk |=>
		localResetNOe && !cardPowerGoodNOe && !cardSignalValidNOe)
		else $error("card rail low without reset");
	a_drv_status: assert property (gateDriverStatusNOe ==
		gateCtrlLowRail)
		else $error("driver status does not follow gates");
	a_gate_ins: assert property (!insDone |=> !gateCtrlLowRail)
		else $error("gates on without full insertion");

	c_fault_cycle: cover property ($fell(faultNOe) && gateCtrlLowRail);
	c_host_reset: cover property (rstStart);
	c_valid_up: cover property ($rose(cardSignalValidNOe));
	c_axi_write: cover property (doWrite && awOfs_q == OFS_CTRL);
endmodule
`default_nettype wire

// ===== dv/hsr_backplane_model.sv
`default_nettype none
// ****************************************
// Backplane and backend wiring around the sequencer
// ****************************************
module hsr_backplane_model (
	// Open-drain drive, {rst, rstN, faultN, validN, goodN, drvN}
	pinOe,
	pinOut,
	// Ejector switches, high means closed to ground
	insAClosed,
	insBClosed,
	// Levels seen on the wires
	pinLevel,
	insertionDetectAN,
	insertionDetectBN
);
	timeunit 1ns;
	timeprecision 1ps;
	input wire logic [5:0] pinOe;
	input wire logic [5:0] pinOut;
	input wire logic insAClosed;
	input wire logic insBClosed;
	output logic [5:0] pinLevel;
	output logic insertionDetectAN;
	output logic insertionDetectBN;
	// Released pins fall to their resistor: high reset pulled low
	assign pinLevel = (pinOe & pinOut) | (~pinOe & 6'h1F);
	// Open switch reads high through the pull-up
	assign insertionDetectAN = insAClosed ? 1'b0 : 1'b1;
	assign insertionDetectBN = insBClosed ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== dv/hot_swap_power_reset_sequencer_test.sv
`default_nettype none
module hot_swap_power_reset_sequencer_test import hsr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	localparam int STRETCH = 20; // Shortened stretch
	localparam int SETTLE = 45; // Sync plus stretch margin
	logic ref_clk = 1'b0, rst = 1'b1, hostResetN = 1'b1;
	logic hostPowerRequest = 1'b0, hostSupplyChoice = 1'b1;
	logic insAClosed = 1'b1, insBClosed = 1'b1;
	logic breakerSenseLowRail = 1'b0, breakerSenseHighRail = 1'b0;
	logic hostLowRailMonitor = 1'b1, mainSupplyMonitor = 1'b1;
	logic cardLowRailMonitor = 1'b1, cardHighRailMonitor = 1'b1;
	logic memAddrStrap1 = 1'b1, memAddrStrap2 = 1'b0;
	logic memAddrStrapUnused = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, memAddrField;
	logic [31:0] rdata;
	logic insertionDetectAN, insertionDetectBN;
	logic gateCtrlLowRail, gateCtrlHighRail, gateDriverStatusNOut;
	logic gateDriverStatusNOe, cardPowerGoodNOut, cardPowerGoodNOe;
	logic cardSignalValidNOut, cardSignalValidNOe, faultNOut, faultNOe;
	logic localResetNOut, localResetNOe, localResetOut, localResetOe;
	logic [5:0] pinLevel;
	int miscompares = 0, cmpCount = 0;
	logic [31:0] rd;
	logic [1:0] rsp;
	// Output snapshot: gates, driver, fault, good, valid, resets
	wire logic [7:0] outs = {gateCtrlLowRail, gateCtrlHighRail,
		gateDriverStatusNOe, faultNOe, cardPowerGoodNOe,
		cardSignalValidNOe, localResetNOe, localResetOe};

	always #2.5 ref_clk = ~ref_clk;

	hsr_sequencer #(.STRETCH_CYCLES(STRETCH)) hsr_sequencer_i (.ref_clk,
		.rst, .hostResetN, .hostPowerRequest, .hostSupplyChoice,
		.insertionDetectAN, .insertionDetectBN, .breakerSenseLowRail,
		.breakerSenseHighRail, .hostLowRailMonitor, .mainSupplyMonitor,
		.cardLowRailMonitor, .cardHighRailMonitor, .memAddrStrap1,
		.memAddrStrap2, .memAddrStrapUnused, .memAddrField,
		.gateCtrlLowRail, .gateCtrlHighRail,
		.gateDriverStatusNIn(pinLevel[0]), .gateDriverStatusNOut,
		.gateDriverStatusNOe, .cardPowerGoodNIn(pinLevel[1]),
		.cardPowerGoodNOut, .cardPowerGoodNOe,
		.cardSignalValidNIn(pinLevel[2]), .cardSignalValidNOut,
		.cardSignalValidNOe, .faultNIn(pinLevel[3]), .faultNOut, .faultNOe,
		.localResetNIn(pinLevel[4]), .localResetNOut, .localResetNOe,
		.localResetIn(pinLevel[5]), .localResetOut, .localResetOe,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp);

	hsr_backplane_model hsr_backplane_model_i (
		.pinOe({localResetOe, localResetNOe, faultNOe, cardSignalValidNOe,
			cardPowerGoodNOe, gateDriverStatusNOe}),
		.pinOut({localResetOut, localResetNOut, faultNOut,
			cardSignalValidNOut, cardPowerGoodNOut, gateDriverStatusNOut}),
		.insAClosed, .insBClosed, .pinLevel, .insertionDetectAN,
		.insertionDetectBN);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Masked compare of the output snapshot
	task automatic chk_out(input logic [7:0] m, input logic [7:0] e);
		chk({24'h0, outs & m}, {24'h0, e});
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		bit done;
		n = 0;
		done = 0;
		// Let an edge pass so bready is never set twice in one step
		@(posedge ref_clk);
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge ref_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1;
			end
		end
		// A write that never answers ends the run as a failure
		if (!done) begin
			miscompares++;
			wrap_up;
		end
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		bit done;
		n = 0;
		done = 0;
		d = 32'h0;
		// Let an edge pass so rready is never set twice in one step
		@(posedge ref_clk);
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 200) begin
			@(posedge ref_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1;
			end
		end
		// A read that never answers ends the run as a failure
		if (!done) begin
			miscompares++;
			wrap_up;
		end
	endtask

	// Reset, then insert the card and request power
	task automatic power_up(input logic choice);
		rst <= 1'b1;
		hostPowerRequest <= 1'b0;
		hostSupplyChoice <= choice;
		cyc(4);
		chk_out(8'hCB, 8'h03);
		rst <= 1'b0;
		insAClosed <= 1'b1;
		insBClosed <= 1'b1;
		hostPowerRequest <= 1'b1;
		cyc(SETTLE);
		chk_out(8'hFF, 8'hEC);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		power_up(1'b1);
		chk({30'h0, memAddrField}, 32'h1);
		$display("test power_up done");
		hostResetN <= 1'b0;
		cyc(8);
		hostResetN <= 1'b1;
		cyc(10);
		chk_out(8'h03, 8'h00);
		hostResetN <= 1'b0;
		cyc(12);
		chk_out(8'h03, 8'h03);
		cyc(30);
		chk_out(8'h03, 8'h03);
		// Stretch already ran out while held low: release ends reset
		hostResetN <= 1'b1;
		cyc(15);
		chk_out(8'h07, 8'h04);
		cyc(SETTLE);
		chk_out(8'hFF, 8'hEC);
		$display("test host_reset done");
		for (int i = 0; i < 2; i++) begin
			if (i == 0) breakerSenseLowRail <= 1'b1;
			else breakerSenseHighRail <= 1'b1;
			cyc(4);
			chk_out(8'hF0, 8'h10);
			breakerSenseLowRail <= 1'b0;
			breakerSenseHighRail <= 1'b0;
			cyc(10);
			chk_out(8'hF0, 8'h10);
			hostPowerRequest <= 1'b0;
			cyc(5);
			chk_out(8'hD3, 8'h13);
			hostPowerRequest <= 1'b1;
			for (int n = 0; n < SETTLE && gateCtrlLowRail !== 1'b1; n++)
				@(posedge ref_clk);
			chk_out(8'hD0, 8'hC0);
			cyc(SETTLE);
		end
		$display("test breaker done");
		for (int i = 0; i < 2; i++) begin
			if (i == 0) cardLowRailMonitor <= 1'b0;
			else cardHighRailMonitor <= 1'b0;
			cyc(5);
			chk_out(8'h0F, 8'h03);
			cardLowRailMonitor <= 1'b1;
			cardHighRailMonitor <= 1'b1;
			cyc(SETTLE);
			chk_out(8'hFF, 8'hEC);
		end
		hostLowRailMonitor <= 1'b0;
		cyc(5);
		chk_out(8'hE7, 8'h03);
		hostLowRailMonitor <= 1'b1;
		mainSupplyMonitor <= 1'b0;
		cyc(SETTLE);
		chk_out(8'hFF, 8'hEC);
		mainSupplyMonitor <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			if (i == 0) insAClosed <= 1'b0;
			else insBClosed <= 1'b0;
			cyc(5);
			chk_out(8'hE0, 8'h00);
			insAClosed <= 1'b1;
			insBClosed <= 1'b1;
			cyc(SETTLE);
		end
		$display("test monitors done");
		axi_rd({28'h0, OFS_STATUS}, rd, rsp);
		chk(rd & 32'h003F001F, 32'h0018000D);
		axi_wr({28'h0, OFS_CTRL}, 32'h1, rsp);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
		cyc(5);
		chk_out(8'h07, 8'h03);
		axi_rd({28'h0, OFS_CTRL}, rd, rsp);
		chk(rd & 32'h1, 32'h1);
		axi_wr({28'h0, OFS_CTRL}, 32'h0, rsp);
		axi_rd({28'h0, OFS_STRAP}, rd, rsp);
		chk(rd & 32'h7, 32'h5);
		axi_rd(32'hC, rd, rsp);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		chk(rd, 32'h0);
		axi_wr({28'h0, OFS_STATUS}, 32'hFFFFFFFF, rsp);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
		cyc(SETTLE);
		chk_out(8'hFF, 8'hEC);
		$display("test registers done");
		power_up(1'b0);
		mainSupplyMonitor <= 1'b0;
		cyc(5);
		chk_out(8'hEF, 8'h03);
		$display("test main_supply done");
		wrap_up;
	end

	// Hang guard well beyond the planned run
	initial begin
		cyc(20000);
		miscompares++;
		wrap_up;
	end
endmodule
`default_nettype wire
